/* dsa_cfg.svh */
// Register offsets, field positions, reset values and codes of the short-address DMA engine
`ifndef DSA_CFG_SVH
`define DSA_CFG_SVH

`define DSA_ADDR_W        8
`define DSA_CH_SHIFT      4
`define DSA_OFF_SRC       2'h0
`define DSA_OFF_DST       2'h1
`define DSA_OFF_CNT       2'h2
`define DSA_OFF_CTL       2'h3

`define DSA_CTL_EN        0
`define DSA_CTL_WORD      1
`define DSA_CTL_DOWN      2
`define DSA_CTL_MODE_LO   3
`define DSA_CTL_SINGLE    5
`define DSA_CTL_MEM_DST   6
`define DSA_CTL_DONE      7
`define DSA_CTL_RSV_LO    8
`define DSA_CTL_BLOCK_MODE_ENABLE      11
`define DSA_CTL_BLKSIDE   12
`define DSA_CTL_RSEL_LO   16
`define DSA_CTL_BUSY      20
`define DSA_CTL_W         20
`define DSA_CTL_RST       20'h00000

`define DSA_MODE_SEQ      2'h0
`define DSA_MODE_IDLE     2'h1
`define DSA_MODE_REP      2'h2

`define DSA_RSEL_SCI_TX   4'h6
`define DSA_RSEL_SCI_RX   4'h7
`define DSA_RSEL_ADC      4'h8
`define DSA_RSEL_EXT      4'h9

`define DSA_RESP_OKAY     2'h0
`define DSA_RESP_SLVERR   2'h2

`endif

/* dsa_pkg.sv */
// Types of the short-address DMA engine
package dsa_pkg;
  typedef enum logic [1:0] {
    DSA_ST_IDLE,
    DSA_ST_RD,
    DSA_ST_WR,
    DSA_ST_SGL
  } dsa_state_t;
endpackage : dsa_pkg

/* dsa_buf.sv */
// Two-entry data buffer with valid/ready on both sides
`timescale 1ns/100ps
module dsa_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("dsa_buf: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [PW:0]      cnt_q;
  wire              push_w = in_valid_i && in_ready_o;
  wire              pop_w  = out_valid_o && out_ready_i;

  assign in_ready_o  = (cnt_q < (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push_w) wp_q <= wp_q + 1'b1;
      if (pop_w) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push_w) - (PW+1)'(pop_w);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push_w) mem_q[wp_q] <= in_data_i;
  end
endmodule : dsa_buf

/* dsa_top.sv */
// Short-address DMA engine: channel registers over AXI4-Lite and the bus-side transfer engine
//
// What this block does
// RULE_01 Block pair: enable clear is normal, 01 destination block, 11 source block.
// RULE_02 Software writes zero to three reserved bits; they stay readable, reset zero.
// RULE_03 Each transfer request moves exactly one byte or one word.
// RULE_04 Dual address: read at source address, then write at destination address.
// RULE_05 Sequential mode steps memory address up or down by 1 or 2.
// RULE_06 Sequential and idle count 1 to 65536 then stop; idle keeps address.
// RULE_07 Repeat mode steps, reloads address and count after 1 to 256, continues.
// RULE_08 Single address: one bus cycle, peripheral chosen by the acknowledge pin.
// RULE_09 Single address offers sequential, idle and repeat modes too.
// RULE_10 Up to four channels; external request and single address only on B channels.
// RULE_11 Requests come from timers, serial events, converter end or external input.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "dsa_cfg.svh"
module dsa_top
  import dsa_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [`DSA_ADDR_W-1:0] s_awaddr,
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  input  wire logic [31:0]           s_wdata,
  input  wire logic [3:0]            s_wstrb,
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  output logic      [1:0]            s_bresp,
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  input  wire logic [`DSA_ADDR_W-1:0] s_araddr,
  output logic                       s_rvalid,
  input  wire logic                  s_rready,
  output logic      [31:0]           s_rdata,
  output logic      [1:0]            s_rresp,
  input  wire logic [5:0]            tmr_match_a_i,
  input  wire logic                  sci_tx_empty_i,
  input  wire logic                  sci_rx_full_i,
  input  wire logic                  adc_end_i,
  input  wire logic [NUM_CH-1:0]     ext_req_i,
  output logic                       mem_req_o,
  output logic                       mem_we_o,
  output logic                       mem_word_o,
  output logic      [31:0]           mem_addr_o,
  output logic      [15:0]           mem_wdata_o,
  input  wire logic [15:0]           mem_rdata_i,
  input  wire logic                  mem_ack_i,
  output logic                       transfer_ack_pin_o
);
  if (NUM_CH < 1 || NUM_CH > 4) begin : g_chk
    $error("dsa_top: NUM_CH must be 1 to 4");
  end

  // Channel state
  logic [31:0]          src_q   [NUM_CH];
  logic [31:0]          dst_q   [NUM_CH];
  logic [15:0]          cnt_q   [NUM_CH];
  logic [31:0]          isrc_q  [NUM_CH];
  logic [31:0]          idst_q  [NUM_CH];
  logic [15:0]          icnt_q  [NUM_CH];
  logic [`DSA_CTL_W-1:0] ctl_q  [NUM_CH];
  logic [NUM_CH-1:0]    done_q;
  logic [NUM_CH-1:0]    pend_q;
  logic [NUM_CH-1:0]    evt_w;
  logic [NUM_CH-1:0]    memdst_w;
  logic [NUM_CH-1:0]    ready_w;
  logic [NUM_CH-1:0]    en_w;

  dsa_state_t state_q;
  logic [1:0]  cur_q;
  logic [31:0] addr_q;
  logic        swe_q;

  wire [8:0] src_vec_w = {adc_end_i, sci_rx_full_i, sci_tx_empty_i, tmr_match_a_i}; // RULE_11

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire [3:0] rsel_w = ctl_q[c][`DSA_CTL_RSEL_LO +: 4];
    // External requests reach odd (B) channels only
    assign evt_w[c] = (rsel_w == `DSA_RSEL_EXT) ? (ext_req_i[c] && (c % 2 == 1)) : // RULE_10 RULE_11
                      (rsel_w < 4'h9) ? src_vec_w[rsel_w] : 1'b0;
    assign memdst_w[c] = ctl_q[c][`DSA_CTL_BLOCK_MODE_ENABLE] ? !ctl_q[c][`DSA_CTL_BLKSIDE] // RULE_01
                                                 : ctl_q[c][`DSA_CTL_MEM_DST];
    assign ready_w[c] = pend_q[c] && ctl_q[c][`DSA_CTL_EN]
                        && (!ctl_q[c][`DSA_CTL_SINGLE] || (c % 2 == 1)); // RULE_10
    assign en_w[c] = ctl_q[c][`DSA_CTL_EN];
  end

  // Lowest channel wins; fixed priority keeps the arbiter tiny
  logic [1:0] sel_w;
  logic       any_w;
  always_comb begin
    sel_w = '0;
    any_w = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (ready_w[i]) begin
        sel_w = 2'(i);
        any_w = 1'b1;
      end
    end
  end

  // Data path buffer between read and write bus cycles
  logic buf_in_ready;
  logic buf_out_valid;
  wire  rd_ack_w  = (state_q == DSA_ST_RD) && mem_ack_i;
  wire  wr_ack_w  = (state_q == DSA_ST_WR) && mem_ack_i;
  wire  fin_w     = wr_ack_w || ((state_q == DSA_ST_SGL) && mem_ack_i);
  wire  start_w   = (state_q == DSA_ST_IDLE) && any_w && buf_in_ready;

  dsa_buf #(.WIDTH(16), .DEPTH(2)) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (rd_ack_w),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (mem_rdata_i),
    .out_valid_o (buf_out_valid),
    .out_ready_i (wr_ack_w),
    .out_data_o  (mem_wdata_o)
  );

  // Unit completion arithmetic for the current channel
  wire [1:0]  mode_w  = ctl_q[cur_q][`DSA_CTL_MODE_LO +: 2];
  wire        rep_w   = (mode_w == `DSA_MODE_REP);
  wire        step_w  = (mode_w != `DSA_MODE_IDLE); // RULE_06
  wire [31:0] delta_w = ctl_q[cur_q][`DSA_CTL_WORD] ? 32'h00000002 : 32'h00000001; // RULE_05
  wire [31:0] maddr_w = memdst_w[cur_q] ? dst_q[cur_q] : src_q[cur_q];
  wire [31:0] mnext_w = !step_w ? maddr_w :
                        ctl_q[cur_q][`DSA_CTL_DOWN] ? maddr_w - delta_w : maddr_w + delta_w; // RULE_05
  // Repeat counts live in the low byte, so 0 there stands for 256
  wire        last_w  = rep_w ? (cnt_q[cur_q][7:0] == 8'h01) : (cnt_q[cur_q] == 16'h0001); // RULE_06 RULE_07

  // AXI4-Lite slave
  logic                   aw_hold_q;
  logic                   w_hold_q;
  logic [`DSA_ADDR_W-1:0] awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   rvalid_q;
  logic [31:0]            rdata_q;
  logic [1:0]             rresp_q;

  assign s_awready = !aw_hold_q && !bvalid_q;
  assign s_wready  = !w_hold_q && !bvalid_q;
  assign s_arready = !rvalid_q;
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;
  assign s_rvalid  = rvalid_q;
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  wire       do_wr_w  = aw_hold_q && w_hold_q && !bvalid_q;
  wire [1:0] wch_w    = awaddr_q[`DSA_CH_SHIFT +: 2];
  wire [1:0] wreg_w   = awaddr_q[3:2];
  wire       wok_w    = (awaddr_q[7:6] == 2'h0) && (32'(wch_w) < NUM_CH);
  wire [1:0] rch_w    = s_araddr[`DSA_CH_SHIFT +: 2];
  wire [1:0] rreg_w   = s_araddr[3:2];
  wire       rok_w    = (s_araddr[7:6] == 2'h0) && (32'(rch_w) < NUM_CH);
  wire [31:0] ctl_rd_w = rok_w ? {11'h000, (state_q != DSA_ST_IDLE) && (cur_q == rch_w),
                                  ctl_q[rch_w][19:8], done_q[rch_w], ctl_q[rch_w][6:0]} : 32'h00000000;
  wire [31:0] rd_w = !rok_w ? 32'h00000000 :
                     (rreg_w == `DSA_OFF_SRC) ? src_q[rch_w] :
                     (rreg_w == `DSA_OFF_DST) ? dst_q[rch_w] :
                     (rreg_w == `DSA_OFF_CNT) ? {16'h0000, cnt_q[rch_w]} : ctl_rd_w;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `DSA_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= `DSA_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
      end
      if (do_wr_w) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wok_w ? `DSA_RESP_OKAY : `DSA_RESP_SLVERR;
      end else if (s_bready) begin
        bvalid_q <= 1'b0;
      end
      if (s_arvalid && s_arready) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_w;
        rresp_q  <= rok_w ? `DSA_RESP_OKAY : `DSA_RESP_SLVERR;
      end else if (s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Channel registers, pending requests and the engine. Engine updates come after
  // software writes, so a finishing unit wins over a same-cycle write to that channel.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        src_q[c]  <= '0;
        dst_q[c]  <= '0;
        cnt_q[c]  <= '0;
        isrc_q[c] <= '0;
        idst_q[c] <= '0;
        icnt_q[c] <= '0;
        ctl_q[c]  <= `DSA_CTL_RST; // RULE_02
      end
      done_q  <= '0;
      pend_q  <= '0;
      state_q <= DSA_ST_IDLE;
      cur_q   <= '0;
      addr_q  <= '0;
      swe_q   <= 1'b0;
    end else begin
      if (do_wr_w && wok_w) begin
        unique case (wreg_w)
          `DSA_OFF_SRC: begin
            src_q[wch_w]  <= merge(src_q[wch_w], wdata_q, wstrb_q);
            isrc_q[wch_w] <= merge(src_q[wch_w], wdata_q, wstrb_q);
          end
          `DSA_OFF_DST: begin
            dst_q[wch_w]  <= merge(dst_q[wch_w], wdata_q, wstrb_q);
            idst_q[wch_w] <= merge(dst_q[wch_w], wdata_q, wstrb_q);
          end
          `DSA_OFF_CNT: begin
            cnt_q[wch_w]  <= 16'(merge({16'h0000, cnt_q[wch_w]}, wdata_q, wstrb_q));
            icnt_q[wch_w] <= 16'(merge({16'h0000, cnt_q[wch_w]}, wdata_q, wstrb_q));
          end
          `DSA_OFF_CTL: begin
            // Reserved bits 10:8 are stored as written
            ctl_q[wch_w]  <= `DSA_CTL_W'(merge(32'(ctl_q[wch_w]), wdata_q, wstrb_q)); // RULE_02
            done_q[wch_w] <= 1'b0;
          end
        endcase
      end
      // New request wins over the grant; a disabled channel keeps none, so enabling never fires a stale one
      pend_q <= ((pend_q & ~(start_w ? (NUM_CH'(1) << sel_w) : '0)) | evt_w) & en_w; // RULE_03
      unique case (state_q)
        DSA_ST_IDLE: begin
          if (start_w) begin
            cur_q <= sel_w;
            if (ctl_q[sel_w][`DSA_CTL_SINGLE]) begin
              addr_q  <= memdst_w[sel_w] ? dst_q[sel_w] : src_q[sel_w]; // RULE_09
              swe_q   <= memdst_w[sel_w];
              state_q <= DSA_ST_SGL; // RULE_08
            end else begin
              addr_q  <= src_q[sel_w]; // RULE_04
              state_q <= DSA_ST_RD;
            end
          end
        end
        DSA_ST_RD: begin
          if (mem_ack_i) begin
            addr_q  <= dst_q[cur_q]; // RULE_04
            state_q <= DSA_ST_WR;
          end
        end
        DSA_ST_WR, DSA_ST_SGL: begin
          if (mem_ack_i) begin
            state_q <= DSA_ST_IDLE; // RULE_03
          end
        end
      endcase
      if (fin_w) begin
        if (last_w && rep_w) begin
          src_q[cur_q] <= isrc_q[cur_q]; // RULE_07
          dst_q[cur_q] <= idst_q[cur_q];
          cnt_q[cur_q] <= icnt_q[cur_q];
        end else begin
          if (memdst_w[cur_q]) dst_q[cur_q] <= mnext_w; // RULE_05
          else src_q[cur_q] <= mnext_w;
          cnt_q[cur_q] <= cnt_q[cur_q] - 16'h0001;
          if (last_w) begin
            ctl_q[cur_q][`DSA_CTL_EN] <= 1'b0; // RULE_06
            done_q[cur_q]             <= 1'b1;
          end
        end
      end
    end
  end

  // Bus strobes; the acknowledge pin replaces the I/O address in single mode
  assign mem_req_o          = (state_q == DSA_ST_WR) ? buf_out_valid : (state_q != DSA_ST_IDLE);
  assign mem_we_o           = (state_q == DSA_ST_WR) || ((state_q == DSA_ST_SGL) && swe_q);
  assign mem_word_o         = ctl_q[cur_q][`DSA_CTL_WORD];
  assign mem_addr_o         = addr_q;
  assign transfer_ack_pin_o = (state_q == DSA_ST_SGL); // RULE_08

  // Checks
  a_rd_then_wr: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    rd_ack_w |=> (state_q == DSA_ST_WR) && mem_we_o && mem_addr_o == $past(dst_q[cur_q]))
    else $error("read cycle not followed by write to destination");
  a_single_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    (transfer_ack_pin_o && mem_ack_i) |=> !transfer_ack_pin_o && state_q == DSA_ST_IDLE)
    else $error("single transfer took more than one bus cycle");
  a_single_bchan: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    transfer_ack_pin_o |-> cur_q[0])
    else $error("single address on an A channel");
  a_one_unit: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    start_w |-> pend_q[sel_w] ##1 (mem_req_o && state_q != DSA_ST_IDLE))
    else $error("unit started without pending request");
  a_unit_end: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    fin_w |=> state_q == DSA_ST_IDLE && !mem_req_o)
    else $error("engine went on without a new request");
  a_seq_step: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    (fin_w && mode_w == `DSA_MODE_SEQ && !last_w && !memdst_w[cur_q] && !ctl_q[cur_q][`DSA_CTL_DOWN])
    |=> src_q[$past(cur_q)] == $past(src_q[cur_q]) + $past(delta_w))
    else $error("sequential address step wrong");
  a_idle_fixed: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
    (fin_w && mode_w == `DSA_MODE_IDLE && !do_wr_w) |=> $stable(src_q[cur_q]) && $stable(dst_q[cur_q]))
    else $error("idle mode address moved");
  a_count_stop: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
    (fin_w && last_w && !rep_w) |=> !ctl_q[$past(cur_q)][`DSA_CTL_EN] && done_q[$past(cur_q)])
    else $error("channel did not stop at count end");
  a_rep_reload: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    (fin_w && last_w && rep_w) |=> cnt_q[$past(cur_q)] == $past(icnt_q[cur_q])
      && ctl_q[$past(cur_q)][`DSA_CTL_EN])
    else $error("repeat mode did not reload");
  a_blk_side: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    (fin_w && ctl_q[cur_q][`DSA_CTL_BLOCK_MODE_ENABLE] && step_w && !last_w && !do_wr_w)
    |=> (ctl_q[cur_q][`DSA_CTL_BLKSIDE] ? ($stable(dst_q[cur_q]) && !$stable(src_q[cur_q]))
                                        : ($stable(src_q[cur_q]) && !$stable(dst_q[cur_q]))))
    else $error("block side select ignored");
endmodule : dsa_top

/* dsa_mem_model.sv */
// Behavioural memory and peripheral on the far side of the DMA bus
`timescale 1ns/100ps
module dsa_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [15:0] mem_wdata_i,
  input  wire logic        pin_i,
  output logic      [15:0] mem_rdata_o,
  output logic             mem_ack_o,
  output int               n_o,
  output logic      [31:0] rd_addr_o,
  output logic      [31:0] wr_addr_o,
  output logic      [15:0] wr_data_o,
  output logic             pin_o
);
  int wait_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {mem_rdata_o, mem_ack_o, rd_addr_o, wr_addr_o, wr_data_o, pin_o} <= '0;
      n_o    <= 0;
      wait_q <= 0;
    end else begin
      mem_ack_o   <= 1'b0;
      // Undriven between cycles: toggle so stale data never looks right
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
        // Wait of zero to two cycles mixes prompt and slow answers
        if (wait_q >= n_o % 3) begin
          mem_ack_o <= 1'b1;
          wait_q    <= 0;
          n_o       <= n_o + 1;
          pin_o     <= pin_i;
          if (mem_we_i) begin
            wr_addr_o <= mem_addr_i;
            wr_data_o <= mem_wdata_i;
          end else begin
            rd_addr_o   <= mem_addr_i;
            mem_rdata_o <= mem_addr_i[15:0] ^ 16'h5a3c;
          end
        end else begin
          wait_q <= wait_q + 1;
        end
      end
    end
  end
endmodule : dsa_mem_model

/* dma_short_address_transfer_tb.sv */
// Self-checking testbench of the short-address DMA engine
`timescale 1ns/100ps
`include "dsa_cfg.svh"
module dma_short_address_transfer_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [7:0]  s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata, mem_addr_o, rd_addr, wr_addr;
  logic [3:0]  s_wstrb = 4'hf, ext_req_i = '0;
  logic [1:0]  s_bresp, s_rresp;
  logic [5:0]  tmr_match_a_i = '0;
  logic        sci_tx_empty_i = 1'b0, sci_rx_full_i = 1'b0, adc_end_i = 1'b0;
  logic        mem_req_o, mem_we_o, mem_word_o, mem_ack_i, transfer_ack_pin_o, pin;
  logic [15:0] mem_wdata_o, mem_rdata_i, wr_data;
  int          n, failures = 0, num_checks = 0;

  always #2 clk_i = ~clk_i;

  dsa_top #(.NUM_CH(4)) u_dut (.clk_i, .rst_i, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid, .s_wready,
    .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr, .s_rvalid,
    .s_rready, .s_rdata, .s_rresp, .tmr_match_a_i, .sci_tx_empty_i, .sci_rx_full_i, .adc_end_i, .ext_req_i,
    .mem_req_o, .mem_we_o, .mem_word_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i,
    .transfer_ack_pin_o);
  dsa_mem_model u_mem (.clk_i, .rst_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .pin_i(transfer_ack_pin_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i),
    .n_o(n), .rd_addr_o(rd_addr), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .pin_o(pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit pa = 1'b1, pw = 1'b1;
    @(posedge clk_i);
    s_awvalid <= 1'b1;
    s_awaddr  <= a;
    s_wvalid  <= 1'b1;
    s_wdata   <= d;
    s_bready  <= 1'b1;
    while (pa || pw) begin
      @(posedge clk_i);
      if (pa && s_awready) begin
        pa = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (pw && s_wready) begin
        pw = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    while (s_bvalid !== 1'b1) begin
      @(posedge clk_i);
    end
    s_bready <= 1'b0;
    chk(32'(s_bresp), 32'(er));
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    s_arvalid <= 1'b1;
    s_araddr  <= a;
    s_rready  <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) begin
      @(posedge clk_i);
    end
    d = s_rdata;
    s_rready <= 1'b0;
    chk(32'(s_rresp), 32'(er));
  endtask : axi_rd

  // Control written last so the channel starts fully programmed
  task automatic setch(input int c, input logic [31:0] s, input logic [31:0] d, input logic [31:0] k,
                       input logic [31:0] ctl);
    logic [7:0] b;
    b = 8'(c << `DSA_CH_SHIFT);
    axi_wr(b + {`DSA_OFF_SRC, 2'b00}, s, `DSA_RESP_OKAY);
    axi_wr(b + {`DSA_OFF_DST, 2'b00}, d, `DSA_RESP_OKAY);
    axi_wr(b + {`DSA_OFF_CNT, 2'b00}, k, `DSA_RESP_OKAY);
    axi_wr(b + {`DSA_OFF_CTL, 2'b00}, ctl, `DSA_RESP_OKAY);
  endtask : setch

  // One request pulse, then count bus cycles and check where they went
  task automatic unit(input int sel, input int c, input int k, input logic [31:0] ra, input logic [31:0] wa);
    int n0 = n, g = 0;
    @(posedge clk_i);
    if (sel < 6) tmr_match_a_i[sel] <= 1'b1;
    if (sel == 6) sci_tx_empty_i <= 1'b1;
    if (sel == 7) sci_rx_full_i <= 1'b1;
    if (sel == 8) adc_end_i <= 1'b1;
    if (sel == 9) ext_req_i[c] <= 1'b1;
    @(posedge clk_i);
    {tmr_match_a_i, sci_tx_empty_i, sci_rx_full_i, adc_end_i, ext_req_i} <= '0;
    while (n < n0 + k && g < 60) begin
      @(posedge clk_i);
      g++;
    end
    repeat (12) @(posedge clk_i);
    chk(32'(n - n0), 32'(k));
    if (k > 0) chk(rd_addr, ra);
    if (k == 1) chk(32'(pin), 32'h1);
    if (k == 2) begin
      chk(32'(wr_addr), wa);
      chk(32'(wr_data[7:0]), 32'(ra[7:0] ^ 8'h3c));
      chk(32'(pin), 32'h0);
    end
  endtask : unit

  task automatic s_regs;
    logic [31:0] d;
    axi_rd(8'h0c, d, `DSA_RESP_OKAY);
    chk(d, 32'(`DSA_CTL_RST));
    axi_wr(8'h2c, 32'h00000700, `DSA_RESP_OKAY);
    axi_rd(8'h2c, d, `DSA_RESP_OKAY);
    chk(d, 32'h00000700);
    axi_wr(8'h2c, 32'h00000000, `DSA_RESP_OKAY);
    axi_rd(8'hc0, d, `DSA_RESP_SLVERR);
    chk(d, 32'h00000000);
    axi_wr(8'h80, 32'h00000001, `DSA_RESP_SLVERR);
  endtask : s_regs

  task automatic s_seq;
    logic [31:0] d;
    setch(0, 32'h100, 32'h200, 32'h2, 32'h00020041);
    unit(2, 0, 2, 32'h100, 32'h200);
    unit(2, 0, 2, 32'h100, 32'h201);
    unit(2, 0, 0, 32'h0, 32'h0);
    axi_rd(8'h0c, d, `DSA_RESP_OKAY);
    chk(32'({d[`DSA_CTL_DONE], d[`DSA_CTL_EN]}), 32'h2);
    chk(32'(mem_word_o), 32'h0);
  endtask : s_seq

  task automatic s_rep;
    setch(0, 32'h10, 32'h500, 32'h2, 32'h00030057);
    unit(3, 0, 2, 32'h10, 32'h500);
    unit(3, 0, 2, 32'h10, 32'h4fe);
    unit(3, 0, 2, 32'h10, 32'h500);
    axi_wr(8'h0c, 32'h0, `DSA_RESP_OKAY);
  endtask : s_rep

  task automatic s_srcs;
    setch(2, 32'h300, 32'h400, 32'h0, 32'h0);
    for (int sel = 0; sel < 9; sel++) begin
      axi_wr(8'h2c, (32'(sel) << `DSA_CTL_RSEL_LO) | 32'h0000000b, `DSA_RESP_OKAY);
      unit(sel, 2, 2, 32'h300, 32'h400);
      chk(32'(mem_word_o), 32'h1);
    end
    axi_wr(8'h2c, 32'h0, `DSA_RESP_OKAY);
  endtask : s_srcs

  task automatic s_single;
    setch(1, 32'h600, 32'h0, 32'h2, 32'h00090021);
    unit(9, 1, 1, 32'h600, 32'h0);
    unit(9, 1, 1, 32'h601, 32'h0);
    setch(0, 32'h700, 32'h0, 32'h2, 32'h00090021);
    unit(9, 0, 0, 32'h0, 32'h0);
    axi_wr(8'h0c, 32'h0, `DSA_RESP_OKAY);
  endtask : s_single

  task automatic s_block;
    setch(3, 32'h700, 32'h800, 32'h2, 32'h00040801);
    unit(4, 3, 2, 32'h700, 32'h800);
    unit(4, 3, 2, 32'h700, 32'h801);
    setch(3, 32'h700, 32'h800, 32'h2, 32'h00041801);
    unit(4, 3, 2, 32'h700, 32'h800);
    unit(4, 3, 2, 32'h701, 32'h800);
  endtask : s_block

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs();
    s_seq();
    s_rep();
    s_srcs();
    s_single();
    s_block();
    print_verdict();
  end

  // Whole run needs about 650 cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    print_verdict();
  end
endmodule : dma_short_address_transfer_tb
